// *** src/csdc_pkg.sv ***
// Purpose: constants and types for the current sense detect control block
// Assumes: byte-wide registers on a plain strobe port, one clock
// Notes:
// How it works
// - amp_enable powers the whole current sense amplifier; zero after reset.
// - gain_high_select zero gives gain 10, high alone gives 30, both undefined.
// - both gain select bits clear at reset, so the lower gain comes up.
// - calibration_enable grounds the amplifier input; otherwise input comes from sense pin.
// - detect_enable enables the detect comparator outside stop mode and the detect pin logic while oscillator pins are not enabled.
// - detect_irq_enable gates whether a detection may interrupt the processor.
// - writing one to detect_flag_clear clears the flag; zero leaves it.
// - detect_flag_clear always reads zero; reset does not touch it.
// - detect_flag sets when the comparator reports voltage at or past trip level.
// - interrupt request stands while flag and interrupt enable are both set.
// - direct writes to the flag are ignored; reset clears it.
// - detect_output_select one picks the second pin, zero the first; reset clears.
// - detect disabled leaves both pins as port bits; else selected pin carries detect.
// - detect shows on a pin only when oscillator pins are not option-enabled.
// - external oscillator option keeps both detect outputs unavailable.
// - in wait mode the logic runs and a detection can wake the processor.
// - in stop mode the block is off, yet a set flag can still wake.

package csdc_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CSDC_ADDR_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] CSDC_ADDR_MISC_CONTROL   = 8'h0b;
	localparam logic [7:0] CSDC_ADDR_IRQ_STATUS     = 8'h01;
	localparam logic [7:0] CSDC_ADDR_IRQ_MASK       = 8'h02;

	// status/control bit positions
	localparam int CSDC_BIT_AMP_EN    = 7;
	localparam int CSDC_BIT_GAIN_HIGH = 6;
	localparam int CSDC_BIT_GAIN_LOW  = 5;
	localparam int CSDC_BIT_CAL_EN    = 4;
	localparam int CSDC_BIT_DET_EN    = 3;
	localparam int CSDC_BIT_DET_IE    = 2;
	localparam int CSDC_BIT_FLAG_CLR  = 1;
	localparam int CSDC_BIT_FLAG      = 0;
	// misc control bit position
	localparam int CSDC_BIT_OUT_SEL   = 0;
	// interrupt status / mask bit positions
	localparam int CSDC_IRQ_DETECT    = 0;
	localparam int CSDC_IRQ_WIDTH     = 1;

	localparam logic [7:0] CSDC_RESET_CONTROL = 8'h00;
	localparam logic       CSDC_RESET_BIT     = 1'b0;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		CSDC_GAIN_10,
		CSDC_GAIN_30,
		CSDC_GAIN_UNDEF
	} csdc_gain_t;

	typedef enum logic [1:0] {
		CSDC_PWR_RUN,
		CSDC_PWR_WAIT,
		CSDC_PWR_STOP
	} csdc_power_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} csdc_bus_req_t;

	typedef struct packed {
		logic       amp_on;
		csdc_gain_t gain;
		logic       cal_ground;
		logic       comp_on;
	} csdc_analog_ctl_t;

	typedef struct packed {
		logic first_is_detect;
		logic first_val;
		logic second_is_detect;
		logic second_val;
	} csdc_pins_t;
endpackage : csdc_pkg

// *** src/csdc_top.sv ***
// Purpose: control/status logic for the current sense amplifier and detect flag
// Assumes: comparator output synchronous to clk_sys; power mode given as input
// Notes: interrupt status bit mirrors detect flag events; write one to clear
//
// The address-and-strobe port was chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module csdc_top (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      srst,
	// register port
	input  wire csdc_pkg::csdc_bus_req_t   bus_req,
	output logic [7:0]                     bus_rdata,
	// analog side
	input  wire logic                      comp_trip,
	output csdc_pkg::csdc_analog_ctl_t     analog_ctl,
	// power and option
	input  wire csdc_pkg::csdc_power_t     power_mode,
	input  wire logic                      osc_pins_enabled,
	// shared pins
	output csdc_pkg::csdc_pins_t           pins,
	// interrupts
	output logic                           detect_irq,
	output logic                           irq,
	output logic                           wake_request
);
	// ****************************************
	// registers
	// ****************************************
	logic amp_enable;
	logic gain_high_select;
	logic gain_low_select;
	logic calibration_enable;
	logic detect_enable;
	logic detect_irq_enable;
	logic detect_flag;
	logic detect_output_select;
	logic [csdc_pkg::CSDC_IRQ_WIDTH-1:0] irq_status;
	logic [csdc_pkg::CSDC_IRQ_WIDTH-1:0] irq_mask;

	// ****************************************
	// decode
	// ****************************************
	wire logic hit_ctl  = bus_req.addr == csdc_pkg::CSDC_ADDR_STATUS_CONTROL;
	wire logic hit_misc = bus_req.addr == csdc_pkg::CSDC_ADDR_MISC_CONTROL;
	wire logic hit_ists = bus_req.addr == csdc_pkg::CSDC_ADDR_IRQ_STATUS;
	wire logic hit_imsk = bus_req.addr == csdc_pkg::CSDC_ADDR_IRQ_MASK;
	wire logic wr_ctl   = bus_req.wr && hit_ctl;
	wire logic wr_misc  = bus_req.wr && hit_misc;
	wire logic wr_ists  = bus_req.wr && hit_ists;
	wire logic wr_imsk  = bus_req.wr && hit_imsk;

	// stop mode powers the block down; wait keeps it running
	wire logic in_stop      = power_mode == csdc_pkg::CSDC_PWR_STOP;
	wire logic comp_active  = detect_enable && !in_stop;
	wire logic detect_event = comp_active && comp_trip;
	wire logic flag_clear   = wr_ctl && bus_req.wdata[csdc_pkg::CSDC_BIT_FLAG_CLR];

	// set wins over the clear
	wire logic next_flag = detect_event || (detect_flag && !flag_clear);
	wire logic [csdc_pkg::CSDC_IRQ_WIDTH-1:0] irq_events = detect_event;
	wire logic [csdc_pkg::CSDC_IRQ_WIDTH-1:0] next_irq_status =
		irq_events | (irq_status & ~(wr_ists ? bus_req.wdata[csdc_pkg::CSDC_IRQ_WIDTH-1:0]
			: {csdc_pkg::CSDC_IRQ_WIDTH{1'b0}}));

	// ****************************************
	// read mux
	// ****************************************
	wire logic [7:0] ctl_view = {amp_enable, gain_high_select, gain_low_select, calibration_enable,
		detect_enable, detect_irq_enable, 1'b0, detect_flag};
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		if (!bus_req.rd) begin
			next_rdata = 8'h00;
		end else if (hit_ctl) begin
			next_rdata = ctl_view;
		end else if (hit_misc) begin
			next_rdata = {7'h00, detect_output_select};
		end else if (hit_ists) begin
			next_rdata = {{(8-csdc_pkg::CSDC_IRQ_WIDTH){1'b0}}, irq_status};
		end else if (hit_imsk) begin
			next_rdata = {{(8-csdc_pkg::CSDC_IRQ_WIDTH){1'b0}}, irq_mask};
		end
	end

	// ****************************************
	// state
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			amp_enable           <= csdc_pkg::CSDC_RESET_BIT;
			gain_high_select     <= csdc_pkg::CSDC_RESET_BIT;
			gain_low_select      <= csdc_pkg::CSDC_RESET_BIT;
			calibration_enable   <= csdc_pkg::CSDC_RESET_BIT;
			detect_enable        <= csdc_pkg::CSDC_RESET_BIT;
			detect_irq_enable    <= csdc_pkg::CSDC_RESET_BIT;
			detect_flag          <= csdc_pkg::CSDC_RESET_BIT;
			detect_output_select <= csdc_pkg::CSDC_RESET_BIT;
			irq_status           <= '0;
			irq_mask             <= '0;
			bus_rdata            <= csdc_pkg::CSDC_RESET_CONTROL;
		end else begin
			if (wr_ctl) begin
				amp_enable         <= bus_req.wdata[csdc_pkg::CSDC_BIT_AMP_EN];
				gain_high_select   <= bus_req.wdata[csdc_pkg::CSDC_BIT_GAIN_HIGH];
				gain_low_select    <= bus_req.wdata[csdc_pkg::CSDC_BIT_GAIN_LOW];
				calibration_enable <= bus_req.wdata[csdc_pkg::CSDC_BIT_CAL_EN];
				detect_enable      <= bus_req.wdata[csdc_pkg::CSDC_BIT_DET_EN];
				detect_irq_enable  <= bus_req.wdata[csdc_pkg::CSDC_BIT_DET_IE];
			end
			if (wr_misc) begin
				detect_output_select <= bus_req.wdata[csdc_pkg::CSDC_BIT_OUT_SEL];
			end
			if (wr_imsk) begin
				irq_mask <= bus_req.wdata[csdc_pkg::CSDC_IRQ_WIDTH-1:0];
			end
			detect_flag <= next_flag;
			irq_status  <= next_irq_status;
			bus_rdata   <= next_rdata;
		end
	end

	// ****************************************
	// analog controls
	// ****************************************
	wire logic amp_on_w = amp_enable && !in_stop;
	wire csdc_pkg::csdc_gain_t gain_w = !gain_high_select ? csdc_pkg::CSDC_GAIN_10
		: (gain_low_select ? csdc_pkg::CSDC_GAIN_UNDEF : csdc_pkg::CSDC_GAIN_30);
	assign analog_ctl.amp_on     = amp_on_w;
	assign analog_ctl.gain       = gain_w;
	assign analog_ctl.cal_ground = calibration_enable;
	assign analog_ctl.comp_on    = comp_active;

	// ****************************************
	// pins and interrupts
	// ****************************************
	// oscillator option steals the pins, so the detect never routes there
	wire logic pin_route = detect_enable && !osc_pins_enabled;
	assign pins.first_is_detect  = pin_route && !detect_output_select;
	assign pins.second_is_detect = pin_route && detect_output_select;
	assign pins.first_val        = pins.first_is_detect && detect_flag;
	assign pins.second_val       = pins.second_is_detect && detect_flag;

	assign detect_irq   = detect_flag && detect_irq_enable;
	// flag stays live in stop, so it can still wake
	assign wake_request = detect_irq;
	assign irq          = |(irq_status & irq_mask);
endmodule : csdc_top

`default_nettype wire

// *** verif/csdc_sense_model.sv ***
// Purpose: sense resistor and comparator seen from the block
// Assumes: over_trip is the bench's choice of current level
// Notes: LAG sets a prompt or a slow comparator
`timescale 1ns/1ps
`default_nettype none
module csdc_sense_model #(parameter int LAG = 1) (
	input  wire logic clk_sys,
	input  wire logic over_trip,
	output logic      comp_trip
);
	logic [7:0] dly = 8'h00;
	always @(posedge clk_sys) dly <= {dly[6:0], over_trip};
	assign comp_trip = dly[LAG-1];
endmodule : csdc_sense_model
`default_nettype wire

// *** verif/csdc_monitor.sv ***
// Purpose: port checks for csdc_top
// Assumes: one clock, srst synchronous
// Notes: the flag is seen through the pin values
`timescale 1ns/1ps
`default_nettype none
module csdc_monitor (
	input wire logic                       clk_sys,
	input wire logic                       srst,
	input wire csdc_pkg::csdc_bus_req_t    bus_req,
	input wire logic [7:0]                 bus_rdata,
	input wire logic                       comp_trip,
	input wire csdc_pkg::csdc_analog_ctl_t analog_ctl,
	input wire csdc_pkg::csdc_power_t      power_mode,
	input wire logic                       osc_pins_enabled,
	input wire csdc_pkg::csdc_pins_t       pins,
	input wire logic                       detect_irq,
	input wire logic                       irq,
	input wire logic                       wake_request
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire ctl_wr = bus_req.wr && bus_req.addr == csdc_pkg::CSDC_ADDR_STATUS_CONTROL;
	wire stop = power_mode == csdc_pkg::CSDC_PWR_STOP;
	chk_irq_wake: assert property (detect_irq == wake_request) else $error("wake differs");
	chk_stop_off: assert property (stop |-> !analog_ctl.amp_on && !analog_ctl.comp_on) else $error("on in stop");
	chk_osc_block: assert property (osc_pins_enabled |-> !pins.first_is_detect && !pins.second_is_detect)
		else $error("detect on oscillator pins");
	chk_pin_excl: assert property (!(pins.first_is_detect && pins.second_is_detect)) else $error("two pins");
	chk_clr_reads0: assert property (bus_req.rd && bus_req.addr == 8'h00 |=> !bus_rdata[1])
		else $error("clear bit read high");
	chk_gain_low: assert property (ctl_wr && !bus_req.wdata[6] |=> analog_ctl.gain == csdc_pkg::CSDC_GAIN_10)
		else $error("gain not 10");
	chk_amp_cal: assert property (ctl_wr |=> stop || analog_ctl.amp_on == $past(bus_req.wdata[7])
		&& analog_ctl.cal_ground == $past(bus_req.wdata[4])) else $error("amp or cal wrong");
	chk_trip_sets: assert property (comp_trip && analog_ctl.comp_on && pins.first_is_detect && !bus_req.wr
		|=> pins.first_val || osc_pins_enabled) else $error("trip missed");
	chk_flag_hold: assert property (pins.first_val && !bus_req.wr |=> pins.first_val || osc_pins_enabled)
		else $error("flag lost");
endmodule : csdc_monitor
bind csdc_top csdc_monitor u_mon (.clk_sys, .srst, .bus_req, .bus_rdata, .comp_trip, .analog_ctl, .power_mode,
	.osc_pins_enabled, .pins, .detect_irq, .irq, .wake_request);
`default_nettype wire

// *** verif/csdc_top_bench.sv ***
// Purpose: self-checking bench for csdc_top
// Assumes: 200 MHz clk_sys, srst held 16 cycles
// Notes: slow comparator, two cycles of lag
`timescale 1ns/1ps
`default_nettype none
module csdc_top_bench;
	logic clk_sys = 1'b0, srst = 1'b1, over_trip = 1'b0, osc_pins_enabled = 1'b0;
	logic comp_trip, detect_irq, irq, wake_request;
	logic [7:0] bus_rdata;
	csdc_pkg::csdc_bus_req_t bus_req = '0;
	csdc_pkg::csdc_power_t power_mode = csdc_pkg::CSDC_PWR_RUN;
	csdc_pkg::csdc_analog_ctl_t analog_ctl;
	csdc_pkg::csdc_pins_t pins;
	int fail_count = 0, checks = 0;
	csdc_sense_model #(.LAG(2)) u_sense (.clk_sys, .over_trip, .comp_trip);
	csdc_top uut (.clk_sys, .srst, .bus_req, .bus_rdata, .comp_trip, .analog_ctl, .power_mode,
		.osc_pins_enabled, .pins, .detect_irq, .irq, .wake_request);
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) bus_req <= {a, d, 2'b10};
		@(posedge clk_sys) bus_req.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys) bus_req <= {a, 8'h00, 2'b01};
		@(posedge clk_sys) bus_req.rd <= 1'b0;
		#1 check(bus_rdata, exp);
	endtask : rd
	task automatic trip(input logic t, input int n);
		@(posedge clk_sys) over_trip <= t;
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : trip
	task automatic wrap_up();
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task automatic s_gain();
		logic [7:0] v [4] = '{8'h80, 8'hc0, 8'he0, 8'h50};
		foreach (v[i]) begin
			wr(8'h00, v[i]);
			check(analog_ctl.gain, v[i][6] ? (v[i][5] ? 2'd2 : 2'd1) : 2'd0);
			check({analog_ctl.amp_on, analog_ctl.cal_ground}, {v[i][7], v[i][4]});
		end
	endtask : s_gain
	task automatic s_detect();
		wr(8'h00, 8'h08);
		check(analog_ctl.comp_on, 1'b1);
		trip(1'b1, 0);
		trip(1'b0, 4);
		check(pins, 8'h0c);
		check(detect_irq, 1'b0);
		wr(8'h00, 8'h0d);
		rd(8'h00, 8'h0d);
		check(detect_irq, 1'b1);
		wr(8'h02, 8'h01);
		check(irq, 1'b1);
		wr(8'h01, 8'h01);
		check(irq, 1'b0);
		wr(8'h0b, 8'h01);
		check(pins, 8'h03);
		@(posedge clk_sys) osc_pins_enabled <= 1'b1;
		#1 check(pins, 8'h00);
		@(posedge clk_sys) osc_pins_enabled <= 1'b0;
		wr(8'h00, 8'h0e);
		rd(8'h00, 8'h0c);
	endtask : s_detect
	task automatic s_power();
		@(posedge clk_sys) power_mode <= csdc_pkg::CSDC_PWR_WAIT;
		trip(1'b1, 0);
		for (int i = 0; i < 8 && detect_irq !== 1'b1; i++) @(posedge clk_sys);
		#1 check(detect_irq, 1'b1);
		if (detect_irq !== 1'b1) wrap_up();
		wr(8'h00, 8'h0e);
		check(detect_irq, 1'b1);
		trip(1'b0, 3);
		@(posedge clk_sys) power_mode <= csdc_pkg::CSDC_PWR_STOP;
		#1 check(analog_ctl, 8'h00);
		check(wake_request, 1'b1);
		wr(8'h00, 8'h0e);
		trip(1'b1, 5);
		check(wake_request, 1'b0);
	endtask : s_power
	// mid-run reset with the flag, status and pin select all set
	task automatic s_reset();
		@(posedge clk_sys) power_mode <= csdc_pkg::CSDC_PWR_RUN;
		repeat (2) @(posedge clk_sys);
		#1 check({detect_irq, irq, wake_request}, 8'h07);
		@(posedge clk_sys) srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		#1 check(analog_ctl, 8'h00);
		check(pins, 8'h00);
		check({detect_irq, irq, wake_request}, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h0b, 8'h00);
		trip(1'b0, 2);
	endtask : s_reset
	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		#1 check(analog_ctl, 8'h00);
		check(pins, 8'h00);
		rd(8'h00, 8'h00);
		rd(8'h0b, 8'h00);
		s_gain();
		s_detect();
		s_power();
		s_reset();
		wrap_up();
	end
endmodule : csdc_top_bench
`default_nettype wire
